// *** hw/branch_pkg.sv ***
/*
 * Constants shared by the conditional short branch unit: opcode
 * encodings, field positions, widths and the instruction cycle phasing.
 * Assumes a core that fetches one 16-bit program word per instruction cycle.
 */
package branch_pkg;
	// Upper nibble common to the short conditional branches
	localparam logic [3:0] GROUP_NIBBLE = 4'he;
	// Second nibble selects the tested flag and sense
	localparam logic [3:0] SEL_NEGATIVE = 4'h6;
	localparam logic [3:0] SEL_SIGN_CLEAR = 4'h7;
	localparam logic [3:0] SEL_CARRY_CLEAR = 4'h3;
	localparam logic [3:0] SEL_NO_OVERFLOW = 4'h5;
	// Field positions inside the instruction word
	localparam int GROUP_MSB = 15;
	localparam int GROUP_LSB = 12;
	localparam int SEL_MSB = 11;
	localparam int SEL_LSB = 8;
	localparam int OFFSET_MSB = 7;
	localparam int OFFSET_LSB = 0;
	// Program counter width and reset value
	localparam int PC_WIDTH = 21;
	localparam logic [PC_WIDTH-1:0] PC_RESET = 21'h000000;
	// Bytes per program word
	localparam logic [PC_WIDTH-1:0] WORD_BYTES = 21'h000002;
	// Clock edges per instruction cycle (four phases)
	localparam int PHASES = 4;
	localparam logic [1:0] PHASE_LAST = 2'h3;
	// Kind of branch found by the decoder
	typedef enum logic [2:0] {
		KIND_NONE,
		KIND_NEGATIVE,
		KIND_SIGN_CLEAR,
		KIND_CARRY_CLEAR,
		KIND_NO_OVERFLOW
	} kind_t;
	// Execution state of the unit
	typedef enum logic [1:0] {
		ST_EXEC,
		ST_FLUSH
	} state_t;
endpackage

// *** hw/branch_if.sv ***
/*
 * Carries the decode result from the decoder to the execute logic.
 * Assumes both ends share the core clock.
 */
`timescale 1ns/10ps
interface branch_if;
	import branch_pkg::*;
	logic [15:0] word; // Instruction word under decode
	logic carry; // Flag levels as read
	logic negative;
	logic overflow;
	kind_t kind; // Which branch, if any
	logic take; // Condition met
	logic signed [8:0] doubledOffset; // Signed, times two; extended to counter width later
	modport decoder (input word, carry, negative, overflow,
		output kind, take, doubledOffset);
	modport exec (output word, carry, negative, overflow,
		input kind, take, doubledOffset);
endinterface

// *** hw/branch_decode.sv ***
/*
 * Combinational decoder for the four short conditional branches.
 * Assumes the flags are stable while the word is presented.
 */
`timescale 1ns/10ps
module branch_decode
	import branch_pkg::*;
(
	branch_if.decoder dec
);
	// Decode group, select and flag condition
	always_comb begin
		dec.kind = KIND_NONE;
		dec.take = 1'b0;
		dec.doubledOffset = {dec.word[OFFSET_MSB:OFFSET_LSB], 1'b0};
		if (dec.word[GROUP_MSB:GROUP_LSB] == GROUP_NIBBLE) begin
			unique case (dec.word[SEL_MSB:SEL_LSB])
				SEL_NEGATIVE: begin
					dec.kind = KIND_NEGATIVE;
					dec.take = dec.negative;
				end
				SEL_SIGN_CLEAR: begin
					dec.kind = KIND_SIGN_CLEAR;
					dec.take = ~dec.negative;
				end
				SEL_CARRY_CLEAR: begin
					dec.kind = KIND_CARRY_CLEAR;
					dec.take = ~dec.carry;
				end
				SEL_NO_OVERFLOW: begin
					dec.kind = KIND_NO_OVERFLOW;
					dec.take = ~dec.overflow;
				end
				// Other selectors belong to other instructions
				default: begin
					dec.kind = KIND_NONE;
					dec.take = 1'b0;
				end
			endcase
		end
	end
endmodule

// *** hw/conditional_short_branch_unit.sv ***
/*
 * Execute logic for the short conditional branches of an 8-bit core.
 * Runs the four-phase instruction cycle, decodes the fetched word at
 * the first phase and writes the program counter at the last phase.
 * Assumes the fetch side presents a word with wordValid at phase 0 of
 * each cycle and that flag inputs come from the status register.
 */
`timescale 1ns/10ps
module conditional_short_branch_unit
	import branch_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [15:0] instrWord,
	input wire logic wordValid,
	input wire logic carryFlag,
	input wire logic negativeFlag,
	input wire logic overflowFlag,
	output logic [PC_WIDTH-1:0] progCounter,
	output logic phaseStart,
	output logic stallFetch,
	output logic branchTaken,
	output logic branchSeen
);
	branch_if bus(); // Decoder link, shared with the decode module
	branch_decode u_decode (
		.dec(bus.decoder)
	);

	// Flags only feed the decoder; nothing in this unit writes them, so
	// the status register keeps its value across every branch form
	assign bus.word = instrWord;
	assign bus.carry = carryFlag; // Carry as read from status
	assign bus.negative = negativeFlag; // Negative as read
	assign bus.overflow = overflowFlag; // Overflow as read

	// The phase counter is two bits wide, so it serves four phases only
	if (PHASES != 4) begin : gPhaseCheck
		$error("phase counter serves exactly four phases");
	end
	// The counter must hold a sign-extended doubled offset
	if (PC_WIDTH < 10) begin : gWidthCheck
		$error("program counter narrower than a doubled offset");
	end

	// Cycle timing group
	logic [1:0] phase; // Position inside the instruction cycle
	logic [1:0] next_phase; // Phase after this edge
	logic next_phaseStart; // High when the next phase is phase 0

	// Execution state group
	state_t state; // Executing or flushing
	state_t next_state; // State after this edge
	logic next_stallFetch; // Fetch hold after this edge

	// Decode hold group: the result latched at the decode phase
	kind_t heldKind; // Which branch, if any
	kind_t next_heldKind; // Kind after this edge
	logic heldTake; // Condition met when decoded
	logic next_heldTake; // Condition after this edge
	logic signed [8:0] heldOffset; // Doubled offset, still signed
	logic signed [8:0] next_heldOffset; // Offset after this edge

	// Counter group
	logic [PC_WIDTH-1:0] next_progCounter; // Counter after this edge

	// Status pulse group
	logic next_branchTaken; // A taken write at this edge
	logic next_branchSeen; // Any decoded branch completes at this edge

	// Phase events shared by every group except cycle timing
	logic decodeNow; // Phase 0 of an executing cycle
	logic writeNow; // Last phase of a cycle that holds a branch
	logic flushEnd; // Last phase of the no-operation cycle

	// Sign extend a doubled offset to counter width; the sign bit is
	// copied up so that a backward branch wraps the counter correctly
	function automatic logic [PC_WIDTH-1:0] extend(
		input logic signed [8:0] v);
		extend = {{(PC_WIDTH-9){v[8]}}, v};
	endfunction

	// True when the unit stands in the given state at the given phase
	function automatic logic atPhase(
		input state_t s,
		input logic [1:0] p,
		input state_t wantState,
		input logic [1:0] wantPhase);
		atPhase = (s == wantState) && (p == wantPhase);
	endfunction

	// Phase events; every group but cycle timing reads these instead of decoding state
	// and phase on its own, so the groups cannot drift apart
	always_comb begin
		decodeNow = atPhase(state, phase, ST_EXEC, 2'h0);
		writeNow = atPhase(state, phase, ST_EXEC, PHASE_LAST) &&
			(heldKind != KIND_NONE);
		flushEnd = atPhase(state, phase, ST_FLUSH, PHASE_LAST);
	end

	// Phase counter runs freely and wraps from the last phase to 0;
	// phaseStart is registered so the fetch side sees a clean level
	always_comb begin
		next_phase = phase + 2'h1;
		next_phaseStart = (next_phase == 2'h0);
	end

	// Phase registers; reset puts the cycle at phase 0
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			phase <= 2'h0;
			phaseStart <= 1'b1;
		end else begin
			phase <= next_phase;
			phaseStart <= next_phaseStart;
		end
	end

	// A taken branch turns the following cycle into a flush
	always_comb begin
		next_state = state;
		next_stallFetch = stallFetch;
		unique case (state)
			ST_EXEC: begin
				// Only a met condition costs the extra cycle
				if (writeNow && heldTake) begin
					next_state = ST_FLUSH;
					next_stallFetch = 1'b1;
				end
			end
			ST_FLUSH: begin
				// Fetch refills during this cycle; no operation here
				if (flushEnd) begin
					next_state = ST_EXEC;
					next_stallFetch = 1'b0;
				end
			end
		endcase
	end

	// State registers; reset leaves the unit executing, fetch free
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state <= ST_EXEC;
			stallFetch <= 1'b0;
		end else begin
			state <= next_state;
			stallFetch <= next_stallFetch;
		end
	end

	// Decode result is latched at phase 0 and used at the last phase,
	// so a word that changes later in the cycle cannot alter the branch
	always_comb begin
		next_heldKind = heldKind;
		next_heldTake = heldTake;
		next_heldOffset = heldOffset;
		if (decodeNow) begin
			// A word not marked valid is a bubble and holds no branch
			if (wordValid) begin
				next_heldKind = bus.kind;
				next_heldTake = bus.take;
			end else begin
				next_heldKind = KIND_NONE;
				next_heldTake = 1'b0;
			end
			next_heldOffset = bus.doubledOffset;
		end else if (flushEnd) begin
			// Drop the spent branch so nothing can replay it
			next_heldKind = KIND_NONE;
			next_heldTake = 1'b0;
		end
	end

	// Decode hold registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			heldKind <= KIND_NONE;
			heldTake <= 1'b0;
			heldOffset <= 9'sh000;
		end else begin
			heldKind <= next_heldKind;
			heldTake <= next_heldTake;
			heldOffset <= next_heldOffset;
		end
	end

	// Counter steps one word at decode and takes the offset at the last
	// phase; the two never meet, as they fall in different phases
	always_comb begin
		next_progCounter = progCounter;
		if (decodeNow && wordValid) begin
			// Step past this word while the next one is fetched
			next_progCounter = progCounter + WORD_BYTES;
		end else if (writeNow && heldTake) begin
			// Counter already holds own address plus two
			next_progCounter = progCounter + extend(heldOffset);
		end else if (writeNow) begin
			// Not taken: counter stays at own address plus two
			next_progCounter = progCounter;
		end
	end

	// Counter register; a bubble leaves it where it is
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			progCounter <= PC_RESET;
		end else begin
			progCounter <= next_progCounter;
		end
	end

	// Pulses mark the write phase: seen for every branch, taken only
	// when the counter was loaded with the target
	always_comb begin
		next_branchSeen = writeNow;
		next_branchTaken = writeNow && heldTake;
	end

	// Pulse registers; each pulse stands for one clock only
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			branchTaken <= 1'b0;
			branchSeen <= 1'b0;
		end else begin
			branchTaken <= next_branchTaken;
			branchSeen <= next_branchSeen;
		end
	end
endmodule

// *** verification/branch_chk.sv ***
/* Checker for the short branch unit.
 * Assumes it is bound to the unit's top-level ports. */
`timescale 1ns/10ps
module branch_chk
	import branch_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [15:0] instrWord,
	input wire logic wordValid,
	input wire logic carryFlag,
	input wire logic negativeFlag,
	input wire logic overflowFlag,
	input wire logic [PC_WIDTH-1:0] progCounter,
	input wire logic phaseStart,
	input wire logic stallFetch,
	input wire logic branchTaken,
	input wire logic branchSeen
);
	logic [3:0] sel; // Selector nibble
	logic isBr; // One of the four branches
	logic take; // Condition met
	logic [PC_WIDTH-1:0] nextPc; // Word after this one
	logic [PC_WIDTH-1:0] target; // Taken destination
	// Own decode, so a slip in the design's decoder cannot hide
	always_comb begin
		sel = instrWord[11:8];
		isBr = wordValid && instrWord[15:12] == 4'he &&
			sel inside {4'h3, 4'h5, 4'h6, 4'h7};
		take = isBr && (sel == 4'h6 ? negativeFlag
			: sel == 4'h3 ? !carryFlag
			: sel == 4'h7 ? !negativeFlag
			: !overflowFlag);
		nextPc = progCounter + WORD_BYTES;
		// Offset doubled and sign-extended to the counter width
		target = nextPc + {{12{instrWord[7]}}, instrWord[7:0], 1'h0};
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence fetch; phaseStart && !stallFetch; endsequence
	step_pc_a: assert property (fetch ##0 wordValid |=>
		progCounter == $past(nextPc)) else $error("pc not one word on");
	taken_pc_a: assert property (fetch ##0 take |-> ##4
		progCounter == $past(target, 4)) else $error("bad branch target");
	taken_pulse_a: assert property (fetch ##0 take |-> ##4
		branchTaken && branchSeen) else $error("taken pulses missing");
	skip_pc_a: assert property (fetch ##0 isBr && !take |-> ##4
		branchSeen && !branchTaken && !stallFetch &&
		progCounter == $past(nextPc, 4)) else $error("bad fall-through");
	plain_word_a: assert property (fetch ##0 !isBr |-> ##4
		!branchSeen && !branchTaken) else $error("pulse on non-branch");
	flush_len_a: assert property ($rose(stallFetch) |->
		stallFetch[*4] ##1 !stallFetch) else $error("flush not 4 clocks");
	flush_hold_a: assert property (stallFetch ##1 stallFetch |->
		$stable(progCounter)) else $error("pc moved during flush");
	bubble_a: assert property (fetch ##0 !wordValid |=>
		$stable(progCounter)) else $error("pc moved on bubble");
	phase_len_a: assert property (fetch |=>
		!phaseStart[*3] ##1 phaseStart) else $error("cycle not 4 edges");
endmodule
bind conditional_short_branch_unit branch_chk branch_chk_i (
	.sys_clk(sys_clk), .rst(rst), .instrWord(instrWord),
	.wordValid(wordValid), .carryFlag(carryFlag),
	.negativeFlag(negativeFlag), .overflowFlag(overflowFlag),
	.progCounter(progCounter), .phaseStart(phaseStart),
	.stallFetch(stallFetch), .branchTaken(branchTaken),
	.branchSeen(branchSeen));

// *** verification/conditional_short_branch_unit_tb_top.sv ***
/* Table-driven bench for the short branch unit.
 * Assumes the unit's ports as declared; no far-side model. */
`timescale 1ns/10ps
module conditional_short_branch_unit_tb_top;
	import branch_pkg::*;
	typedef struct {logic [15:0] w; logic [2:0] f; logic v; logic tk;} row_t;
	logic sys_clk, rst, wordValid, carryFlag, negativeFlag, overflowFlag;
	logic [15:0] instrWord;
	logic [PC_WIDTH-1:0] progCounter;
	logic phaseStart, stallFetch, branchTaken, branchSeen;
	int fails = 0;
	int checks = 0;
	// Word, flags {carry,negative,overflow}, valid, expect taken
	row_t rows [11] = '{'{16'he310, 3'h0, 1'h1, 1'h1},
		'{16'he310, 3'h4, 1'h1, 1'h0}, '{16'he780, 3'h0, 1'h1, 1'h1},
		'{16'he77f, 3'h2, 1'h1, 1'h0}, '{16'he57f, 3'h0, 1'h1, 1'h1},
		'{16'he501, 3'h1, 1'h1, 1'h0}, '{16'he6ff, 3'h2, 1'h1, 1'h1},
		'{16'he605, 3'h5, 1'h1, 1'h0}, '{16'he122, 3'h0, 1'h1, 1'h0},
		'{16'h9c00, 3'h7, 1'h1, 1'h0}, '{16'he310, 3'h0, 1'h0, 1'h0}};
	conditional_short_branch_unit conditional_short_branch_unit_i (
		.sys_clk(sys_clk), .rst(rst), .instrWord(instrWord),
		.wordValid(wordValid), .carryFlag(carryFlag),
		.negativeFlag(negativeFlag), .overflowFlag(overflowFlag),
		.progCounter(progCounter), .phaseStart(phaseStart),
		.stallFetch(stallFetch), .branchTaken(branchTaken),
		.branchSeen(branchSeen));
	task automatic chk(input string nm, input logic [PC_WIDTH-1:0] e, s);
		checks++;
		if (s !== e) begin
			fails++;
			$display("mismatch %s exp %h got %h", nm, e, s);
		end
	endtask
	// One word at a phase-0 slot; word stays up through any flush
	task automatic run(input row_t r);
		logic [PC_WIDTH-1:0] e;
		logic sn;
		while (phaseStart !== 1'h1 || stallFetch !== 1'h0) @(negedge sys_clk);
		sn = r.v && r.w[15:8] inside {8'he3, 8'he5, 8'he6, 8'he7};
		e = progCounter + (r.v ? WORD_BYTES : 21'h0) +
			(r.tk ? {{12{r.w[7]}}, r.w[7:0], 1'h0} : 21'h0);
		instrWord = r.w;
		{carryFlag, negativeFlag, overflowFlag} = r.f;
		wordValid = r.v;
		repeat (4) @(negedge sys_clk);
		chk("pc", e, progCounter);
		chk("taken", 21'(r.tk), 21'(branchTaken));
		chk("seen", 21'(sn), 21'(branchSeen));
	endtask
	// Awkward cases: a word offered mid-flush is refused, then a reset
	// lands in the middle of a second flush
	task automatic flush_cases;
		logic [PC_WIDTH-1:0] e;
		run(rows[0]);
		e = progCounter;
		instrWord = 16'he3f0;
		repeat (4) @(negedge sys_clk);
		chk("flushpc", e, progCounter);
		chk("flushst", 21'h0, 21'(stallFetch));
		run(rows[0]);
		repeat (2) @(negedge sys_clk);
		rst = 1'h1;
		@(negedge sys_clk);
		chk("rstpc", PC_RESET, progCounter);
		chk("rstph", 21'h1, 21'(phaseStart));
		chk("rstst", 21'h0, 21'(stallFetch));
		rst = 1'h0;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		sys_clk = 1'h0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Whole table plus reset stays well under this span
	initial begin
		#20000;
		fails++;
		tally_and_finish();
	end
	initial begin
		{rst, wordValid, carryFlag, negativeFlag, overflowFlag} = 5'h10;
		instrWord = 16'h0;
		repeat (12) @(negedge sys_clk);
		rst = 1'h0;
		foreach (rows[i]) run(rows[i]);
		flush_cases();
		run(rows[6]);
		tally_and_finish();
	end
endmodule
